// *** core/gpio_port_pkg.sv ***
// shared constants and types of the eight-pin bidirectional port
package gpio_port_pkg;

	// ****************************************
	// register map (byte addresses, low 8 bits decoded)
	// ****************************************
	localparam logic [7:0] OFF_PIN_DATA = 8'h00;
	localparam logic [7:0] OFF_DIRECTION = 8'h04;
	localparam logic [7:0] OFF_LATCH = 8'h08;
	localparam logic [7:0] OFF_CONTROL = 8'h0c;
	localparam logic [7:0] OFF_STATUS = 8'h10;

	// ****************************************
	// reset values and field positions
	// ****************************************
	localparam logic [7:0] DIR_RESET = 8'hff;
	localparam logic [7:0] LATCH_RESET = 8'h00;
	localparam logic [7:0] SLV_IN_RESET = 8'h00;
	localparam int CTRL_SLV_SEL_BIT = 0;
	localparam int STAT_IBF_BIT = 0;
	localparam int STAT_OBF_BIT = 1;
	localparam int STAT_ACTIVE_BIT = 2;

	// ****************************************
	// port geometry
	// ****************************************
	localparam int PORT_WIDTH = 8;
	localparam int PWM_COUNT = 4;
	localparam int PWM_PIN_BASE = 4;

	// ****************************************
	// types
	// ****************************************
	typedef enum logic [1:0] {
		BUS_IDLE,
		BUS_WRITE,
		BUS_READ_WAIT
	} bus_phase_type;

	typedef struct packed {
		logic [7:0] oe;
		logic [7:0] value;
	} pin_drive_type;

	typedef struct packed {
		logic cs_n;
		logic rd_n;
		logic wr_n;
	} slv_strobe_type;

endpackage : gpio_port_pkg

// *** core/gpio_sync2.sv ***
// two-flop synchroniser for pin-level inputs
`timescale 1ns/1ps

module gpio_sync2 #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// raw and synchronised levels
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] stage1_r;
	logic [WIDTH-1:0] stage2_r;

	// ****************************************
	// first flop feeds only the second
	// ****************************************
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			stage1_r <= RESET_VALUE;
			stage2_r <= RESET_VALUE;
		end else begin
			stage1_r <= async_in;
			stage2_r <= stage1_r;
		end
	end

	assign sync_out = stage2_r;

endmodule : gpio_sync2

// *** core/gpio_port_core.sv ***
// eight-pin bidirectional port with ahb-lite registers and parallel slave mode
// What this block does
// R01 - eight pins, one register bit each
// R02 - direction one: driver off, pin input
// R03 - direction zero: pin driven from latch
// R04 - latch register readable, returns latch value
// R05 - each pin direction set independently
// R06 - pwm outputs take over their pins
// R07 - reset makes all pins inputs
// R08 - select bit turns port into slave port
// R09 - dual/quad pwm disables slave port
// R10 - data write hits latch, read gives pins, or the slave input byte while slave port active
`timescale 1ns/1ps

module gpio_port_core (
	// clock and reset
	input wire logic SYS_CLK_IN,
	input wire logic RST_IN,
	// ahb-lite slave
	input wire logic HSEL_IN,
	input wire logic [31:0] HADDR_IN,
	input wire logic [1:0] HTRANS_IN,
	input wire logic HWRITE_IN,
	input wire logic [2:0] HSIZE_IN,
	input wire logic [31:0] HWDATA_IN,
	input wire logic HREADY_IN,
	output logic [31:0] HRDATA_OUT,
	output logic HREADYOUT_OUT,
	output logic HRESP_OUT,
	// port pins
	input wire logic [7:0] PIN_IN,
	output logic [7:0] PIN_OUT_OUT,
	output logic [7:0] PIN_OE_OUT,
	// parallel slave strobes from the external processor
	input wire logic SLV_CS_N_IN,
	input wire logic SLV_RD_N_IN,
	input wire logic SLV_WR_N_IN,
	// capture/pwm unit, same clock
	input wire logic [3:0] PWM_VALUE_IN,
	input wire logic [3:0] PWM_OWN_IN,
	input wire logic PWM_MULTI_IN
);

	// ****************************************
	// declarations
	// ****************************************
	gpio_port_pkg::bus_phase_type phase_r, phase_nxt;
	logic [7:0] addr_r, addr_nxt;
	logic [31:0] hrdata_r, hrdata_nxt;
	logic hready_r, hready_nxt;
	logic [7:0] dir_r, dir_nxt;
	logic [7:0] latch_r, latch_nxt;
	logic slv_sel_r, slv_sel_nxt;
	logic [7:0] slv_in_r, slv_in_nxt;
	logic ibf_r, ibf_nxt;
	logic obf_r, obf_nxt;
	logic wr_act_r, wr_act_nxt;
	logic rd_act_r, rd_act_nxt;
	gpio_port_pkg::pin_drive_type drive_r, drive_nxt;
	logic [7:0] pin_s;
	gpio_port_pkg::slv_strobe_type strobe_s;
	logic take;
	logic slv_act;

	// address match on the decoded low byte
	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		return a == off;
	endfunction : hit

	// ****************************************
	// pin and strobe synchronisers
	// ****************************************
	gpio_sync2 #(
		.WIDTH(11),
		.RESET_VALUE(11'h007)
	) u_sync (
		.clk_in(SYS_CLK_IN),
		.rst_in(RST_IN),
		.async_in({PIN_IN, SLV_CS_N_IN, SLV_RD_N_IN, SLV_WR_N_IN}),
		.sync_out({pin_s, strobe_s})
	);

	// slave port only while selected and no multi-output pwm
	assign slv_act = slv_sel_r & ~PWM_MULTI_IN; // R08 R09
	assign take = HSEL_IN & HTRANS_IN[1] & HREADY_IN;

	// ****************************************
	// bus phase tracking
	// ****************************************
	// reads take one wait state so read data comes from a flop
	always_comb begin
		phase_nxt = phase_r;
		addr_nxt = addr_r;
		hrdata_nxt = hrdata_r;
		hready_nxt = 1'b1;
		case (phase_r)
			gpio_port_pkg::BUS_READ_WAIT: begin
				phase_nxt = gpio_port_pkg::BUS_IDLE;
				if (hit(addr_r, gpio_port_pkg::OFF_PIN_DATA))
					hrdata_nxt = {24'h0, slv_act ? slv_in_r : pin_s}; // R10
				else if (hit(addr_r, gpio_port_pkg::OFF_DIRECTION))
					hrdata_nxt = {24'h0, dir_r};
				else if (hit(addr_r, gpio_port_pkg::OFF_LATCH))
					hrdata_nxt = {24'h0, latch_r}; // R04
				else if (hit(addr_r, gpio_port_pkg::OFF_CONTROL))
					hrdata_nxt = {31'h0, slv_sel_r};
				else if (hit(addr_r, gpio_port_pkg::OFF_STATUS))
					hrdata_nxt = {29'h0, slv_act, obf_r, ibf_r};
				else
					hrdata_nxt = 32'h0; // unmapped reads zero
			end
			default: begin
				if (take) begin
					addr_nxt = HADDR_IN[7:0];
					if (HWRITE_IN) begin
						phase_nxt = gpio_port_pkg::BUS_WRITE;
					end else begin
						phase_nxt = gpio_port_pkg::BUS_READ_WAIT;
						hready_nxt = 1'b0;
					end
				end else begin
					phase_nxt = gpio_port_pkg::BUS_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge SYS_CLK_IN) begin
		if (RST_IN) begin
			phase_r <= gpio_port_pkg::BUS_IDLE;
			addr_r <= 8'h00;
			hrdata_r <= 32'h0;
			hready_r <= 1'b1;
		end else begin
			phase_r <= phase_nxt;
			addr_r <= addr_nxt;
			hrdata_r <= hrdata_nxt;
			hready_r <= hready_nxt;
		end
	end

	assign HRDATA_OUT = hrdata_r;
	assign HREADYOUT_OUT = hready_r;
	assign HRESP_OUT = 1'b0;

	// ****************************************
	// port registers and slave port handshake
	// ****************************************
	// sets of ibf (external write) and obf (software write) win over a clear in the same cycle
	always_comb begin
		dir_nxt = dir_r;
		latch_nxt = latch_r;
		slv_sel_nxt = slv_sel_r;
		slv_in_nxt = slv_in_r;
		ibf_nxt = ibf_r;
		obf_nxt = obf_r;
		wr_act_nxt = wr_act_r;
		rd_act_nxt = rd_act_r;
		if (phase_r == gpio_port_pkg::BUS_WRITE) begin
			if (hit(addr_r, gpio_port_pkg::OFF_PIN_DATA) || hit(addr_r, gpio_port_pkg::OFF_LATCH)) begin
				latch_nxt = HWDATA_IN[7:0]; // R10 R04
				if (slv_act && hit(addr_r, gpio_port_pkg::OFF_PIN_DATA))
					obf_nxt = 1'b1;
			end
			if (hit(addr_r, gpio_port_pkg::OFF_DIRECTION))
				dir_nxt = HWDATA_IN[7:0]; // R05
			if (hit(addr_r, gpio_port_pkg::OFF_CONTROL))
				slv_sel_nxt = HWDATA_IN[gpio_port_pkg::CTRL_SLV_SEL_BIT];
		end
		// software read of the data register while the slave port is active empties the input buffer
		if (phase_r == gpio_port_pkg::BUS_READ_WAIT && slv_act && hit(addr_r, gpio_port_pkg::OFF_PIN_DATA))
			ibf_nxt = 1'b0;
		// external write: sample pins while strobed, flag at strobe end
		if (slv_act && !strobe_s.cs_n && !strobe_s.wr_n) begin
			slv_in_nxt = pin_s; // R08
			wr_act_nxt = 1'b1;
		end else if (wr_act_r) begin
			wr_act_nxt = 1'b0;
			ibf_nxt = 1'b1;
		end
		// external read: output buffer counts as taken at strobe end
		if (slv_act && !strobe_s.cs_n && !strobe_s.rd_n) begin
			rd_act_nxt = 1'b1;
		end else if (rd_act_r) begin
			rd_act_nxt = 1'b0;
			if (!(phase_r == gpio_port_pkg::BUS_WRITE && hit(addr_r, gpio_port_pkg::OFF_PIN_DATA)))
				obf_nxt = 1'b0;
		end
	end

	always_ff @(posedge SYS_CLK_IN) begin
		if (RST_IN) begin
			dir_r <= gpio_port_pkg::DIR_RESET; // R07
			latch_r <= gpio_port_pkg::LATCH_RESET;
			slv_sel_r <= 1'b0;
			slv_in_r <= gpio_port_pkg::SLV_IN_RESET;
			ibf_r <= 1'b0;
			obf_r <= 1'b0;
			wr_act_r <= 1'b0;
			rd_act_r <= 1'b0;
		end else begin
			dir_r <= dir_nxt;
			latch_r <= latch_nxt;
			slv_sel_r <= slv_sel_nxt;
			slv_in_r <= slv_in_nxt;
			ibf_r <= ibf_nxt;
			obf_r <= obf_nxt;
			wr_act_r <= wr_act_nxt;
			rd_act_r <= rd_act_nxt;
		end
	end

	// ****************************************
	// pin drivers
	// ****************************************
	// pwm ownership beats slave port, slave port beats direction bits
	always_comb begin
		drive_nxt.oe = ~dir_r; // R01 R02 R03 R05
		drive_nxt.value = latch_r; // R03
		if (slv_act)
			drive_nxt.oe = (!strobe_s.cs_n && !strobe_s.rd_n) ? 8'hff : 8'h00; // R08
		for (int k = 0; k < gpio_port_pkg::PWM_COUNT; k++) begin
			if (PWM_OWN_IN[k]) begin
				drive_nxt.oe[gpio_port_pkg::PWM_PIN_BASE + k] = 1'b1; // R06
				drive_nxt.value[gpio_port_pkg::PWM_PIN_BASE + k] = PWM_VALUE_IN[k];
			end
		end
	end

	always_ff @(posedge SYS_CLK_IN) begin
		if (RST_IN) begin
			drive_r <= {8'h00, 8'h00};
		end else begin
			drive_r <= drive_nxt;
		end
	end

	assign PIN_OE_OUT = drive_r.oe;
	assign PIN_OUT_OUT = drive_r.value;

	// ****************************************
	// assertions
	// ****************************************
	property p_dir_input;
		@(posedge SYS_CLK_IN) disable iff (RST_IN)
		(dir_r[3] && !slv_act) |=> !PIN_OE_OUT[3];
	endproperty
	a_dir_input: assert property (p_dir_input) else $error("input pin still driven"); // R02

	property p_dir_output;
		@(posedge SYS_CLK_IN) disable iff (RST_IN)
		(!dir_r[2] && !slv_act) |=> (PIN_OE_OUT[2] && PIN_OUT_OUT[2] == $past(latch_r[2]));
	endproperty
	a_dir_output: assert property (p_dir_output) else $error("output pin not driven from latch"); // R03

	property p_dir_each;
		@(posedge SYS_CLK_IN) disable iff (RST_IN)
		(!slv_act && PWM_OWN_IN == 4'h0) |=> (PIN_OE_OUT == ~$past(dir_r));
	endproperty
	a_dir_each: assert property (p_dir_each) else $error("enables do not follow direction bits"); // R05

	property p_latch_read;
		@(posedge SYS_CLK_IN) disable iff (RST_IN)
		(phase_r == gpio_port_pkg::BUS_READ_WAIT && addr_r == gpio_port_pkg::OFF_LATCH)
		|=> (HREADYOUT_OUT && HRDATA_OUT[7:0] == $past(latch_r));
	endproperty
	a_latch_read: assert property (p_latch_read) else $error("latch read wrong"); // R04

	property p_reset_dir;
		@(posedge SYS_CLK_IN) disable iff (RST_IN)
		$past(RST_IN) |-> (dir_r == 8'hff && PIN_OE_OUT == 8'h00);
	endproperty
	a_reset_dir: assert property (p_reset_dir) else $error("pins not inputs after reset"); // R07

	property p_pwm_take;
		@(posedge SYS_CLK_IN) disable iff (RST_IN)
		PWM_OWN_IN[1] |=> (PIN_OE_OUT[5] && PIN_OUT_OUT[5] == $past(PWM_VALUE_IN[1]));
	endproperty
	a_pwm_take: assert property (p_pwm_take) else $error("pwm does not own its pin"); // R06

	property p_slv_read;
		@(posedge SYS_CLK_IN) disable iff (RST_IN)
		(slv_act && !strobe_s.cs_n && !strobe_s.rd_n && PWM_OWN_IN == 4'h0)
		|=> (PIN_OE_OUT == 8'hff && PIN_OUT_OUT == $past(latch_r));
	endproperty
	a_slv_read: assert property (p_slv_read) else $error("slave read does not drive latch"); // R08

	property p_slv_off;
		@(posedge SYS_CLK_IN) disable iff (RST_IN)
		(PWM_MULTI_IN && dir_r == 8'hff && PWM_OWN_IN == 4'h0) |=> (PIN_OE_OUT == 8'h00);
	endproperty
	a_slv_off: assert property (p_slv_off) else $error("slave port active under multi pwm"); // R09

	property p_data_write;
		@(posedge SYS_CLK_IN) disable iff (RST_IN)
		(phase_r == gpio_port_pkg::BUS_WRITE && addr_r == gpio_port_pkg::OFF_PIN_DATA)
		|=> (latch_r == $past(HWDATA_IN[7:0]));
	endproperty
	a_data_write: assert property (p_data_write) else $error("data write missed latch"); // R10

	property p_data_read;
		@(posedge SYS_CLK_IN) disable iff (RST_IN)
		(phase_r == gpio_port_pkg::BUS_READ_WAIT && addr_r == gpio_port_pkg::OFF_PIN_DATA && !slv_act)
		|=> (HRDATA_OUT[7:0] == $past(pin_s) && HRDATA_OUT[31:8] == 24'h0);
	endproperty
	a_data_read: assert property (p_data_read) else $error("data read not pin levels"); // R10

endmodule : gpio_port_core

// *** dv/gpio_pin_partner.sv ***
// far-side model of the eight port pins
`timescale 1ns/1ps

module gpio_pin_partner (
	// clock
	input wire logic clk_in,
	// drive from the port
	input wire logic [7:0] port_oe_in,
	input wire logic [7:0] port_val_in,
	// drive from the far side
	input wire logic [7:0] ext_oe_in,
	input wire logic [7:0] ext_val_in,
	// resolved pin levels
	output logic [7:0] level_out
);
	logic [7:0] float_r = 8'h55;

	// a pin nobody drives has no pull, so it flips every cycle
	always @(posedge clk_in) begin
		float_r <= ~float_r;
	end

	// port driver first, then the far side, then the floating pattern
	assign level_out = (port_oe_in & port_val_in) | (~port_oe_in & ext_oe_in & ext_val_in)
		| (~port_oe_in & ~ext_oe_in & float_r);
endmodule : gpio_pin_partner

// *** dv/eight_bit_bidir_port_tb.sv ***
// self-checking bench of the eight-pin port
`timescale 1ns/1ps

module eight_bit_bidir_port_tb;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic hready;
	logic hresp;
	logic [7:0] pin_level;
	logic [7:0] pin_out;
	logic [7:0] pin_oe;
	logic cs_n = 1'b1;
	logic rd_n = 1'b1;
	logic wr_n = 1'b1;
	logic [3:0] pwm_val = 4'h0;
	logic [3:0] pwm_own = 4'h0;
	logic pwm_multi = 1'b0;
	logic [7:0] ext_oe = 8'h00;
	logic [7:0] ext_val = 8'h00;
	logic [31:0] rd;
	logic [7:0] dir;
	logic [7:0] lat;
	logic [7:0] ext;
	int n_fail = 0;
	int comparisons = 0;
	// rows: direction, latch, far-side value
	localparam logic [23:0] ROWS [5] = '{24'hcf30a5, 24'h00ff00, 24'hf05ac3, 24'h55aa0f, 24'hff3c81};

	// ****************************************
	// clock, design and far side
	// ****************************************
	always #10 clk = ~clk;

	gpio_port_core dut (
		.SYS_CLK_IN(clk), .RST_IN(rst), .HSEL_IN(hsel), .HADDR_IN(haddr), .HTRANS_IN(htrans),
		.HWRITE_IN(hwrite), .HSIZE_IN(3'h2), .HWDATA_IN(hwdata), .HREADY_IN(hready),
		.HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready), .HRESP_OUT(hresp), .PIN_IN(pin_level),
		.PIN_OUT_OUT(pin_out), .PIN_OE_OUT(pin_oe), .SLV_CS_N_IN(cs_n), .SLV_RD_N_IN(rd_n),
		.SLV_WR_N_IN(wr_n), .PWM_VALUE_IN(pwm_val), .PWM_OWN_IN(pwm_own), .PWM_MULTI_IN(pwm_multi)
	);

	gpio_pin_partner partner (
		.clk_in(clk), .port_oe_in(pin_oe), .port_val_in(pin_out), .ext_oe_in(ext_oe),
		.ext_val_in(ext_val), .level_out(pin_level)
	);

	// ****************************************
	// tasks
	// ****************************************
	// compare and count
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	// one single ahb-lite word transfer, waiting on hready in both phases
	task ahb(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] r);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		do @(posedge clk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		do @(posedge clk); while (hready !== 1'b1);
		r = hrdata;
		chk("hresp", {31'h0, hresp}, 32'h0);
	endtask : ahb

	// verdict and end of run
	task report_and_stop;
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : report_and_stop

	// ****************************************
	// tests
	// ****************************************
	// watchdog well beyond the expected few hundred cycles
	initial begin
		#(20 * 4000);
		n_fail++;
		report_and_stop();
	end

	// main sequence
	initial begin
		repeat (16) @(posedge clk);
		chk("oe_in_reset", {24'h0, pin_oe}, 32'h0);
		rst <= 1'b0;
		@(posedge clk);
		ahb(1'b0, gpio_port_pkg::OFF_DIRECTION, 8'h00, rd);
		chk("dir_reset", rd, {24'h0, gpio_port_pkg::DIR_RESET});
		ahb(1'b0, gpio_port_pkg::OFF_LATCH, 8'h00, rd);
		chk("latch_reset", rd, 32'h0);
		ahb(1'b0, 8'h14, 8'h00, rd);
		chk("unmapped", rd, 32'h0);
		$display("reset test done");
		// table of direction and latch settings
		for (int i = 0; i < 5; i++) begin
			{dir, lat, ext} = ROWS[i];
			ext_oe <= dir;
			ext_val <= ext;
			ahb(1'b1, gpio_port_pkg::OFF_DIRECTION, dir, rd);
			ahb(1'b1, gpio_port_pkg::OFF_LATCH, lat, rd);
			repeat (4) @(posedge clk);
			chk("pin_oe", {24'h0, pin_oe}, {24'h0, ~dir});
			chk("pin_out", {24'h0, pin_out & ~dir}, {24'h0, lat & ~dir});
			ahb(1'b0, gpio_port_pkg::OFF_PIN_DATA, 8'h00, rd);
			chk("pin_data", rd, {24'h0, (dir & ext) | (~dir & lat)});
			ahb(1'b0, gpio_port_pkg::OFF_LATCH, 8'h00, rd);
			chk("latch", rd, {24'h0, lat});
		end
		$display("table test done");
		// pwm takes pins 4..7 while direction says input
		pwm_own <= 4'hf;
		pwm_val <= 4'ha;
		repeat (3) @(posedge clk);
		chk("pwm_oe", {28'h0, pin_oe[7:4]}, 32'hf);
		chk("pwm_out", {28'h0, pin_out[7:4]}, 32'ha);
		pwm_own <= 4'h0;
		$display("pwm test done");
		// external processor writes a byte into the slave port
		ahb(1'b1, gpio_port_pkg::OFF_CONTROL, 8'h01, rd);
		ext_oe <= 8'hff;
		ext_val <= 8'h5a;
		cs_n <= 1'b0;
		wr_n <= 1'b0;
		repeat (5) @(posedge clk);
		cs_n <= 1'b1;
		wr_n <= 1'b1;
		repeat (6) @(posedge clk);
		ahb(1'b0, gpio_port_pkg::OFF_STATUS, 8'h00, rd);
		chk("status_ibf", rd, 32'h5);
		ahb(1'b0, gpio_port_pkg::OFF_PIN_DATA, 8'h00, rd);
		chk("slave_in", rd, 32'h5a);
		// external processor reads the byte that software left
		ext_oe <= 8'h00;
		ahb(1'b1, gpio_port_pkg::OFF_PIN_DATA, 8'h3c, rd);
		ahb(1'b0, gpio_port_pkg::OFF_STATUS, 8'h00, rd);
		chk("status_obf", rd, 32'h6);
		cs_n <= 1'b0;
		rd_n <= 1'b0;
		repeat (5) @(posedge clk);
		chk("slave_oe", {24'h0, pin_oe}, 32'hff);
		chk("slave_out", {24'h0, pin_out}, 32'h3c);
		cs_n <= 1'b1;
		rd_n <= 1'b1;
		repeat (6) @(posedge clk);
		ahb(1'b0, gpio_port_pkg::OFF_STATUS, 8'h00, rd);
		chk("status_idle", rd, 32'h4);
		// dual or quad pwm switches the slave port off
		pwm_multi <= 1'b1;
		repeat (3) @(posedge clk);
		ahb(1'b0, gpio_port_pkg::OFF_STATUS, 8'h00, rd);
		chk("status_off", rd, 32'h0);
		// a slave read strobe must not turn the drivers on under multi pwm
		cs_n <= 1'b0;
		rd_n <= 1'b0;
		repeat (5) @(posedge clk);
		chk("multi_oe", {24'h0, pin_oe}, 32'h0);
		cs_n <= 1'b1;
		rd_n <= 1'b1;
		$display("slave port test done");
		repeat (3) @(posedge clk);
		// reset in mid-run puts every pin back to input
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		chk("oe_after_reset", {24'h0, pin_oe}, 32'h0);
		ahb(1'b0, gpio_port_pkg::OFF_DIRECTION, 8'h00, rd);
		chk("dir_after_reset", rd, {24'h0, gpio_port_pkg::DIR_RESET});
		ahb(1'b0, gpio_port_pkg::OFF_CONTROL, 8'h00, rd);
		chk("control_after_reset", rd, 32'h0);
		$display("mid-run reset test done");
		report_and_stop();
	end
endmodule : eight_bit_bidir_port_tb
